/* File: hw/atf_task_file.sv */
// task file register bank of a serial storage device, carried in register frames
`timescale 1ns/1ps
`include "atf_defs.svh"

module atf_task_file
    import atf_pkg::*;
#(
    parameter int DATA_W = `ATF_DATA_W
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_clk_en,
    input  wire atf_h2d_t    i_h2d,
    output atf_d2h_t         o_d2h,
    output atf_cmd_t         o_cmd,
    input  wire logic        i_drive_ready,
    input  wire logic        i_write_fault,
    input  wire logic        i_sector_done,
    input  wire logic        i_corrected,
    input  wire logic        i_cmd_end,
    input  wire atf_causes_t i_causes,
    input  wire atf_word_t   i_host_word,
    output logic             o_host_ready,
    output atf_word_t        o_buf_word,
    input  wire logic        i_buf_ready,
    input  wire atf_word_t   i_buf_rd_word,
    output logic             o_buf_rd_ready,
    output atf_word_t        o_host_rd_word,
    input  wire logic        i_host_rd_ready
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    // the frame word carriers are fixed at sixteen bits
    generate
        if (DATA_W != `ATF_DATA_W) begin : g_bad_width
            $error("atf_task_file: DATA_W must be 16");
        end
    endgenerate

    // ****************************************************************
    // state
    // ****************************************************************
    atf_state_t state_ff;
    atf_state_t nxt_state;

    logic [7:0] cause_bits;
    logic       cause_any;
    logic [8:0] left_after;
    logic       send_frame;
    logic [7:0] status_byte;

    // error cause byte assembled from the engine outcome
    always_comb begin
        cause_bits = `ATF_RST_BYTE;
        cause_bits[`ATF_ERR_BAD_BLOCK] = i_causes.bad_block_flag;
        cause_bits[`ATF_ERR_UNCORR]    = i_causes.uncorrectable_flag;
        cause_bits[`ATF_ERR_NOT_FOUND] = i_causes.sector_not_found_flag;
        cause_bits[`ATF_ERR_ABORTED]   = i_causes.command_aborted_flag;
        cause_bits[`ATF_ERR_GENERAL]   = i_causes.general_error_flag;
        cause_any = |cause_bits;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.d2h.valid = 1'b0;
        nxt_state.cmd.valid = 1'b0;
        send_frame = 1'b0;
        left_after = state_ff.remaining;
        status_byte = `ATF_RST_BYTE;

        if (state_ff.wr_word.valid && i_buf_ready) begin
            nxt_state.wr_word.valid = 1'b0;
        end
        if (state_ff.wr_ready && i_host_word.valid) begin
            nxt_state.wr_word = i_host_word;
        end
        // buffer words out to the host
        if (state_ff.rd_word.valid && i_host_rd_ready) begin
            nxt_state.rd_word.valid = 1'b0;
        end
        if (state_ff.rd_ready && i_buf_rd_word.valid) begin
            nxt_state.rd_word = i_buf_rd_word;
        end

        // a correction does not end the command; it is set only while busy, so it never meets the accept clear
        if (state_ff.phase == ATF_BUSY && i_corrected) begin
            nxt_state.corr_seen = 1'b1;
        end

        case (state_ff.phase)
            ATF_IDLE: begin
                // writes while busy are refused, so only idle frames load registers
                if (i_h2d.valid) begin
                    nxt_state.feature  = i_h2d.feature;
                    nxt_state.count    = i_h2d.count;
                    // start sector or address low byte
                    nxt_state.lba_low  = i_h2d.lba_low;
                    // cylinder low or address mid byte
                    nxt_state.lba_mid  = i_h2d.lba_mid;
                    // cylinder high or address high byte
                    nxt_state.lba_high = i_h2d.lba_high;
                    // drive select bit ignored, one device only
                    nxt_state.device   = (i_h2d.device & `ATF_DEV_HEAD_MASK)
                                       | (i_h2d.device & (8'h01 << `ATF_DEV_LBA_BIT))
                                       | `ATF_DEV_FIXED_ONES;
                    if (i_h2d.is_cmd) begin
                        nxt_state.error     = `ATF_RST_BYTE;
                        nxt_state.err_flag  = 1'b0;
                        nxt_state.corr_seen = 1'b0;
                        nxt_state.remaining = (i_h2d.count == 8'h00) ? `ATF_SECTORS_ZERO
                                                                     : {1'b0, i_h2d.count};
                        if (!i_drive_ready || i_write_fault) begin
                            // abort on not ready or write fault
                            nxt_state.error[`ATF_ERR_ABORTED] = 1'b1;
                            nxt_state.err_flag = 1'b1;
                            send_frame = 1'b1;
                        end else begin
                            nxt_state.phase       = ATF_BUSY;
                            nxt_state.cmd.valid   = 1'b1;
                            nxt_state.cmd.command = i_h2d.command;
                            nxt_state.cmd.feature = i_h2d.feature;
                            nxt_state.cmd.sectors = nxt_state.remaining;
                            nxt_state.cmd.lba_mode = i_h2d.device[`ATF_DEV_LBA_BIT];
                            // head select bits complete the address
                            nxt_state.cmd.address = {i_h2d.device[3:0], i_h2d.lba_high,
                                                     i_h2d.lba_mid, i_h2d.lba_low};
                        end
                    end
                end
            end
            ATF_BUSY: begin
                if (i_sector_done && state_ff.remaining != 9'h000) begin
                    left_after = 9'(state_ff.remaining - 9'h001);
                end
                nxt_state.remaining = left_after;
                if (i_cmd_end) begin
                    nxt_state.phase    = ATF_IDLE;
                    nxt_state.error    = cause_bits;
                    nxt_state.err_flag = cause_any;
                    // success leaves zero, failure leaves the rest
                    nxt_state.count    = cause_any ? left_after[7:0] : 8'h00;
                    send_frame = 1'b1;
                end
            end
            default: begin
                nxt_state.phase = ATF_IDLE;
            end
        endcase

        // status only leaves in completion frames
        status_byte[`ATF_ST_BUSY]     = 1'b0;
        status_byte[`ATF_ST_READY]    = i_drive_ready;
        status_byte[`ATF_ST_WFAULT]   = i_write_fault;
        status_byte[`ATF_ST_SEEKDONE] = i_drive_ready;
        status_byte[`ATF_ST_DATAREQ]  = 1'b0;
        status_byte[`ATF_ST_CORR]     = nxt_state.corr_seen;
        // error flag in status bit 0
        status_byte[`ATF_ST_ERR]      = nxt_state.err_flag;

        if (send_frame) begin
            // completion frame carries status, error, count, address and device registers, but not feature
            nxt_state.d2h.valid    = 1'b1;
            nxt_state.d2h.status   = status_byte;
            // unused cause positions forced to zero
            nxt_state.d2h.error    = nxt_state.error & `ATF_ERR_LIVE_MASK;
            nxt_state.d2h.count    = nxt_state.count;
            nxt_state.d2h.lba_low  = nxt_state.lba_low;
            nxt_state.d2h.lba_mid  = nxt_state.lba_mid;
            nxt_state.d2h.lba_high = nxt_state.lba_high;
            nxt_state.d2h.device   = nxt_state.device;
        end

        // data moves only while a command runs; registered ready avoids a loop
        nxt_state.wr_ready = (nxt_state.phase == ATF_BUSY) && !nxt_state.wr_word.valid;
        nxt_state.rd_ready = (nxt_state.phase == ATF_BUSY) && !nxt_state.rd_word.valid;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_ff <= '0;
        end else if (i_clk_en) begin
            state_ff <= nxt_state;
        end
    end

    assign o_d2h          = state_ff.d2h;
    assign o_cmd          = state_ff.cmd;
    assign o_host_ready   = state_ff.wr_ready;
    assign o_buf_word     = state_ff.wr_word;
    assign o_buf_rd_ready = state_ff.rd_ready;
    assign o_host_rd_word = state_ff.rd_word;

endmodule

/* File: include/atf_defs.svh */
// width, bit positions, masks, reset values and counts of the task file register block
`ifndef ATF_DEFS_SVH
`define ATF_DEFS_SVH

`define ATF_DATA_W          16
// error cause bit positions
`define ATF_ERR_BAD_BLOCK   7
`define ATF_ERR_UNCORR      6
`define ATF_ERR_NOT_FOUND   4
`define ATF_ERR_ABORTED     2
`define ATF_ERR_GENERAL     0
// positions that exist in the error byte; the rest read zero
`define ATF_ERR_LIVE_MASK   8'hd5
// status bit positions
`define ATF_ST_BUSY         7
`define ATF_ST_READY        6
`define ATF_ST_WFAULT       5
`define ATF_ST_SEEKDONE     4
`define ATF_ST_DATAREQ      3
`define ATF_ST_CORR         2
`define ATF_ST_ERR          0
// drive/head byte fields
`define ATF_DEV_LBA_BIT     6
`define ATF_DEV_FIXED_ONES  8'ha0
`define ATF_DEV_HEAD_MASK   8'h0f
// sector count meaning of a zero load
`define ATF_SECTORS_ZERO    9'h100
// reset values
`define ATF_RST_BYTE        8'h00
`define ATF_RST_WORD        16'h0000

`endif

/* File: include/atf_pkg.sv */
// types of the task file register block
package atf_pkg;

    typedef enum logic {
        ATF_IDLE,
        ATF_BUSY
    } atf_phase_t;

    // register contents carried by a host-to-device frame
    typedef struct packed {
        logic       valid;
        logic       is_cmd;
        logic [7:0] command;
        logic [7:0] feature;
        logic [7:0] count;
        logic [7:0] lba_low;
        logic [7:0] lba_mid;
        logic [7:0] lba_high;
        logic [7:0] device;
    } atf_h2d_t;

    // register contents carried by a device-to-host frame
    typedef struct packed {
        logic       valid;
        logic [7:0] status;
        logic [7:0] error;
        logic [7:0] count;
        logic [7:0] lba_low;
        logic [7:0] lba_mid;
        logic [7:0] lba_high;
        logic [7:0] device;
    } atf_d2h_t;

    // command handed to the media engine
    typedef struct packed {
        logic        valid;
        logic [7:0]  command;
        logic [7:0]  feature;
        logic [8:0]  sectors;
        logic        lba_mode;
        logic [27:0] address;
    } atf_cmd_t;

    typedef struct packed {
        logic bad_block_flag;
        logic uncorrectable_flag;
        logic sector_not_found_flag;
        logic command_aborted_flag;
        logic general_error_flag;
    } atf_causes_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } atf_word_t;

    typedef struct packed {
        atf_phase_t phase;
        logic [7:0] feature;
        logic [7:0] count;
        logic [7:0] lba_low;
        logic [7:0] lba_mid;
        logic [7:0] lba_high;
        logic [7:0] device;
        logic [7:0] error;
        logic       err_flag;
        logic       corr_seen;
        logic [8:0] remaining;
        atf_d2h_t   d2h;
        atf_cmd_t   cmd;
        atf_word_t  wr_word;
        logic       wr_ready;
        atf_word_t  rd_word;
        logic       rd_ready;
    } atf_state_t;

endpackage

/* File: verif/atf_engine_model.sv */
// media engine stand-in: moves sectors, then ends the command with causes
`timescale 1ns/1ps
module atf_engine_model
    import atf_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire atf_cmd_t    i_cmd,
    input  wire logic [8:0]  i_limit,
    input  wire atf_causes_t i_fail,
    output logic             o_sector_done,
    output logic             o_cmd_end,
    output atf_causes_t      o_causes
);
    // ****************
    // sector engine
    // ****************
    logic       busy_ff;
    logic [8:0] left_ff;
    // stopping after i_limit sectors models a transfer that breaks off part way
    always_ff @(posedge i_clock) begin
        o_sector_done <= 1'b0;
        o_cmd_end     <= 1'b0;
        if (i_rst) begin
            busy_ff  <= 1'b0;
            left_ff  <= 9'h000;
            o_causes <= '0;
        end else if (i_cmd.valid) begin
            busy_ff <= 1'b1;
            left_ff <= (i_cmd.sectors < i_limit) ? i_cmd.sectors : i_limit;
        end else if (busy_ff && left_ff != 9'h000) begin
            o_sector_done <= 1'b1;
            left_ff       <= left_ff - 9'h001;
        end else if (busy_ff) begin
            o_cmd_end <= 1'b1;
            o_causes  <= i_fail;
            busy_ff   <= 1'b0;
        end
    end
endmodule

/* File: verif/atf_task_file_properties.sv */
// port assertions of the task file block
`timescale 1ns/1ps
module atf_task_file_properties
    import atf_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_clk_en,
    input wire atf_h2d_t    i_h2d,
    input wire atf_d2h_t    o_d2h,
    input wire atf_cmd_t    o_cmd,
    input wire logic        i_cmd_end,
    input wire atf_causes_t i_causes
);
    // ****************
    // frame checks
    // ****************
    atf_h2d_t h2d_q;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // follow the design's freeze so a held command still meets its frame
    always_ff @(posedge i_clock) if (i_clk_en) h2d_q <= i_h2d;
    AST_RESERVED_ZERO: assert property (o_d2h.valid |-> (o_d2h.error & 8'h2a) == 8'h00)
        else $error("reserved error bit set");
    AST_ERR_FLAG: assert property (o_d2h.valid |-> o_d2h.status[0] == (|o_d2h.error))
        else $error("error flag disagrees with causes");
    AST_BAD_BLOCK: assert property (i_clk_en && i_cmd_end && i_causes.bad_block_flag |=>
        o_d2h.error[7]) else $error("bad block bit missing");
    AST_UNCORR: assert property (i_clk_en && i_cmd_end && i_causes.uncorrectable_flag |=>
        o_d2h.error[6]) else $error("uncorrectable bit missing");
    AST_NOT_FOUND: assert property (i_clk_en && i_cmd_end && i_causes.sector_not_found_flag |=>
        o_d2h.error[4]) else $error("not found bit missing");
    AST_ABORTED: assert property (i_clk_en && i_cmd_end && i_causes.command_aborted_flag |=>
        o_d2h.error[2]) else $error("abort bit missing");
    AST_GENERAL: assert property (i_clk_en && i_cmd_end && i_causes.general_error_flag |=>
        o_d2h.error[0]) else $error("general bit missing");
    AST_CLEAN_END: assert property (i_clk_en && i_cmd_end && i_causes == '0 |=>
        o_d2h.valid &&
        o_d2h.count == 8'h00 && o_d2h.error == 8'h00) else $error("clean end wrong");
    AST_SECTORS: assert property (o_cmd.valid |-> o_cmd.sectors ==
        (h2d_q.count == 8'h00 ? 9'h100 : {1'b0, h2d_q.count})) else $error("sector count wrong");
    AST_ADDRESS: assert property (o_cmd.valid |-> o_cmd.address ==
        {h2d_q.device[3:0], h2d_q.lba_high, h2d_q.lba_mid, h2d_q.lba_low})
        else $error("address wrong");
endmodule
bind atf_task_file atf_task_file_properties u_props (
    .i_clock  (i_clock),
    .i_rst    (i_rst),
    .i_clk_en (i_clk_en),
    .i_h2d    (i_h2d),
    .o_d2h    (o_d2h),
    .o_cmd    (o_cmd),
    .i_cmd_end(i_cmd_end),
    .i_causes (i_causes)
);

/* File: verif/testbench.sv */
// self-checking bench of the task file block
`timescale 1ns/1ps
module testbench
    import atf_pkg::*;
;
    // ****************
    // stimulus and checks
    // ****************
    logic        i_clock, i_rst, drive_ready, sector_done, cmd_end, host_ready, rd_ready;
    logic        clk_en, write_fault, corrected, buf_ready;
    logic [8:0]  limit;
    atf_h2d_t    h2d;
    atf_d2h_t    d2h, d2h_seen;
    atf_cmd_t    cmd, cmd_seen;
    atf_causes_t causes, fail;
    atf_word_t   host_word, buf_word, buf_rd_word, host_rd_word;
    int          fail_count, checks_done, n;
    int          cycles = 0;
    atf_task_file uut (
        .i_clock(i_clock), .i_rst(i_rst), .i_clk_en(clk_en), .i_h2d(h2d), .o_d2h(d2h),
        .o_cmd(cmd), .i_drive_ready(drive_ready), .i_write_fault(write_fault),
        .i_sector_done(sector_done), .i_corrected(corrected), .i_cmd_end(cmd_end),
        .i_causes(causes), .i_host_word(host_word), .o_host_ready(host_ready),
        .o_buf_word(buf_word), .i_buf_ready(buf_ready), .i_buf_rd_word(buf_rd_word),
        .o_buf_rd_ready(rd_ready), .o_host_rd_word(host_rd_word), .i_host_rd_ready(1'b1)
    );
    atf_engine_model engine (
        .i_clock(i_clock), .i_rst(i_rst), .i_cmd(cmd), .i_limit(limit), .i_fail(fail),
        .o_sector_done(sector_done), .o_cmd_end(cmd_end), .o_causes(causes)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic run_cmd(input logic [7:0] cnt, dev, input logic [8:0] lim,
                           input atf_causes_t why);
        @(posedge i_clock);
        limit <= lim;
        fail  <= why;
        h2d   <= {2'b11, 8'h20, 8'h00, cnt, 8'h12, 8'h34, 8'h56, dev};
        @(posedge i_clock);
        h2d.valid <= 1'b0;
        cmd_seen = '0;
        d2h_seen = '0;
        // bounded wait: a lost completion shows up as a failed check, not a hang
        repeat (400) begin
            #1;
            if (cmd.valid) cmd_seen = cmd;
            if (d2h.valid) break;
            @(posedge i_clock);
        end
        d2h_seen = d2h;
        check(d2h_seen.valid, 1'b1);
    endtask
    task automatic test_words();
        repeat (4) @(posedge i_clock);
        buf_ready <= 1'b0;
        host_word <= {1'b1, 16'hbeef};
        // hold the word until the edge at which ready is sampled high
        for (n = 0; n < 20; n++) begin
            @(posedge i_clock);
            if (host_ready === 1'b1) break;
        end
        host_word.valid <= 1'b0;
        repeat (2) @(posedge i_clock);
        #1;
        check(buf_word, {1'b1, 16'hbeef});
        check(host_ready, 1'b0);
        @(posedge i_clock);
        buf_ready <= 1'b1;
        @(posedge i_clock);
        #1;
        check(buf_word.valid, 1'b0);
        @(posedge i_clock);
        buf_rd_word <= {1'b1, 16'h1234};
        for (n = 0; n < 20; n++) begin
            @(posedge i_clock);
            if (rd_ready === 1'b1) break;
        end
        buf_rd_word.valid <= 1'b0;
        corrected         <= 1'b1;
        #1;
        check(host_rd_word, {1'b1, 16'h1234});
        @(posedge i_clock);
        corrected <= 1'b0;
    endtask
    task automatic test_freeze();
        @(posedge i_clock);
        clk_en <= 1'b0;
        h2d    <= {2'b11, 8'h20, 8'h00, 8'h01, 8'h12, 8'h34, 8'h56, 8'he0};
        @(posedge i_clock);
        h2d.valid <= 1'b0;
        #1;
        check(cmd.valid, 1'b0);
        repeat (2) @(posedge i_clock);
        #1;
        check(host_ready, 1'b0);
        @(posedge i_clock);
        clk_en <= 1'b1;
        $display("freeze test done");
    endtask
    task automatic test_address();
        run_cmd(8'h03, 8'hf5, 9'h1ff, '0);
        check(d2h_seen.device, 8'he5);
        check({d2h_seen.lba_high, d2h_seen.lba_mid, d2h_seen.lba_low}, 24'h56_3412);
        check(d2h_seen.status, 8'h50);
        check(cmd_seen.sectors, 9'h003);
        check(cmd_seen.address, 28'h556_3412);
        check(cmd_seen.lba_mode, 1'b1);
        check(d2h_seen.count, 8'h00);
        check(d2h_seen.status[0], 1'b0);
        run_cmd(8'h01, 8'ha3, 9'h1ff, '0);
        check(cmd_seen.address, 28'h356_3412);
        check(cmd_seen.lba_mode, 1'b0);
        $display("address test done");
    endtask
    task automatic test_full_count();
        fork
            run_cmd(8'h00, 8'he0, 9'h1ff, '0);
            test_words();
        join
        check(cmd_seen.sectors, 9'h100);
        check(d2h_seen.status, 8'h54);
        check(d2h_seen.count, 8'h00);
        $display("full count test done");
    endtask
    task automatic test_failure();
        logic [7:0] emap [5] = '{8'h01, 8'h04, 8'h10, 8'h40, 8'h80};
        run_cmd(8'h05, 8'he0, 9'h002, 5'h12);
        check(d2h_seen.count, 8'h03);
        check(d2h_seen.error, 8'h84);
        check(d2h_seen.status[0], 1'b1);
        check(d2h_seen.status, 8'h51);
        for (int i = 0; i < 5; i++) begin
            run_cmd(8'h01, 8'he0, 9'h000, 5'h01 << i);
            check(d2h_seen.error, emap[i]);
            check(d2h_seen.count, 8'h01);
        end
        run_cmd(8'h01, 8'he0, 9'h1ff, '0);
        check(d2h_seen.error, 8'h00);
        drive_ready <= 1'b0;
        run_cmd(8'h01, 8'he0, 9'h1ff, '0);
        check(cmd_seen.valid, 1'b0);
        check(d2h_seen.error, 8'h04);
        check(d2h_seen.status, 8'h01);
        drive_ready <= 1'b1;
        write_fault <= 1'b1;
        run_cmd(8'h01, 8'he0, 9'h1ff, '0);
        check(cmd_seen.valid, 1'b0);
        check(d2h_seen.error, 8'h04);
        check(d2h_seen.status, 8'h71);
        write_fault <= 1'b0;
        $display("failure test done");
    endtask
    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    initial begin
        i_rst = 1'b1;
        drive_ready = 1'b1;
        clk_en = 1'b1;
        write_fault = 1'b0;
        corrected = 1'b0;
        buf_ready = 1'b1;
        h2d = '0;
        limit = 9'h000;
        fail = '0;
        host_word = '0;
        buf_rd_word = '0;
        fail_count = 0;
        checks_done = 0;
        repeat (12) @(posedge i_clock);
        i_rst <= 1'b0;
        test_address();
        test_full_count();
        test_failure();
        test_freeze();
        end_of_test();
    end
    // the whole run needs well under a thousand cycles
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
endmodule
